// ### design/tone_regs_pkg.sv
// Constants and types for the tone, mute and converter source control registers
package tone_regs_pkg;

  // ------------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_TONE = 8'h12;
  localparam logic [7:0] ADDR_MUTE = 8'h13;
  localparam logic [7:0] ADDR_SRC  = 8'h14;

  // ------------------------------------------------------------------
  // Field positions (most significant bit of each field)
  // ------------------------------------------------------------------
  localparam int PROF_MSB    = 15;
  localparam int TREBLE_MSB  = 13;
  localparam int BASS_MSB    = 11;
  localparam int FAST_BIT    = 15;
  localparam int SILENCE_BIT = 14;
  localparam int GAIN_BIT    = 13;
  localparam int DEEMPH_MSB  = 10;
  localparam int POL_BIT     = 15;
  localparam int RATE_BIT    = 14;
  localparam int SRC_MSB     = 9;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    PROF_FLAT  = 2'h0,
    PROF_MIN   = 2'h1,
    PROF_UNDEF = 2'h2,
    PROF_MAX   = 2'h3
  } tone_profile_t;

  typedef enum logic [1:0] {
    SRC_SER_PLL_SPDIF = 2'h0,
    SRC_SER_PLL_WS    = 2'h1,
    SRC_SPDIF_PLL     = 2'h2,
    SRC_SER_XTAL      = 2'h3
  } src_sel_t;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam tone_profile_t PROF_RST    = PROF_FLAT;
  localparam logic [1:0]    TREBLE_RST  = 2'h0;
  localparam logic [3:0]    BASS_RST    = 4'h0;
  localparam logic          FAST_RST    = 1'b0;
  localparam logic          SILENCE_RST = 1'b1;
  localparam logic          GAIN_RST    = 1'b0;
  localparam logic [2:0]    DEEMPH_RST  = 3'h0;
  localparam logic          POL_RST     = 1'b0;
  localparam logic          RATE_RST    = 1'b1;
  localparam src_sel_t      SRC_RST     = SRC_SPDIF_PLL;

  // ------------------------------------------------------------------
  // Tone limits in dB and operating modes
  // ------------------------------------------------------------------
  localparam logic [4:0] BASS_MIN_CAP_DB = 5'h12;
  localparam logic [4:0] BASS_MAX_CAP_DB = 5'h18;
  localparam logic [2:0] DEEMPH_NONE     = 3'h0;
  localparam logic [3:0] MODE_AUTO_A     = 4'h1;
  localparam logic [3:0] MODE_AUTO_B     = 4'h3;
  localparam logic [3:0] MODE_DE_LO      = 4'h4;
  localparam logic [3:0] MODE_DE_HI      = 4'h8;

endpackage

// ### design/tone_ctrl_if.sv
// Carrier between the register bank and the tone decoder
`timescale 1ns/1ps
interface tone_ctrl_if;
  import tone_regs_pkg::*;
  tone_profile_t profile;
  logic [1:0]    treble_code;
  logic [3:0]    bass_code;
  logic [2:0]    treble_db;
  logic [4:0]    bass_db;

  modport regs (output profile, output treble_code, output bass_code,
                input treble_db, input bass_db);
  modport dec  (input profile, input treble_code, input bass_code,
                output treble_db, output bass_db);
endinterface

// ### design/tone_decode.sv
// Tone decoder: profile, treble and bass codes to boost in dB
`timescale 1ns/1ps
module tone_decode (
  tone_ctrl_if.dec t
);
  import tone_regs_pkg::*;

  logic [4:0] bass_raw;

  // ------------------------------------------------------------------
  // Treble and bass boost, two dB per code step
  // ------------------------------------------------------------------
  always_comb begin
    bass_raw = {t.bass_code, 1'b0};
    unique case (t.profile)
      PROF_MIN: begin
        t.treble_db = {t.treble_code, 1'b0};
        t.bass_db   = (bass_raw > BASS_MIN_CAP_DB) ? BASS_MIN_CAP_DB : bass_raw;
      end
      PROF_MAX: begin
        t.treble_db = {t.treble_code, 1'b0};
        t.bass_db   = (bass_raw > BASS_MAX_CAP_DB) ? BASS_MAX_CAP_DB : bass_raw;
      end
      PROF_FLAT, PROF_UNDEF: begin
        // Flat, and the undefined code, give no boost
        t.treble_db = 3'h0;
        t.bass_db   = 5'h0;
      end
    endcase
  end

endmodule

// ### design/audio_tone_mute_source_regs.sv
// Write-only tone, mute and converter source control registers
`timescale 1ns/1ps

// Contract
// - Bits 15:14 of 12H pick tone profile: 00 flat (reset), 01 min, 11 max.
// - Treble bits 13:12 give 0 dB flat or undefined (10); otherwise 0, 2, 4, 6 dB.
// - Bass bits 11:8 give 0 dB flat or undefined (10); else 2 dB steps, capped 18 or 24.
// - Bit 15 of 13H: 0 soft mute (reset), 1 quick mute.
// - Output muted while mute bit (reset 1) or mute pin is high.
// - Bit 13 of 13H: interpolator gain 0 dB (reset) or 6 dB.
// - Bits 10:8 of 13H: de-emphasis none (reset), 32, 44.1, 48 kHz.
// - De-emphasis field acts in modes 4 to 8; modes 1, 3 apply it automatically.
// - Bit 15 of 14H inverts converter output polarity; reset leaves it unchanged.
// - Bit 14 of 14H selects sample-rate range; reset is the high range.
// - Bits 9:8 of 14H choose data source, clock source, PLL input; reset 10.
// - Codes: 00 serial/PLL/SPDIF, 01 serial/PLL/WS, 10 SPDIF/PLL/SPDIF, 11 serial/crystal.
module audio_tone_mute_source_regs (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire logic                  wr_en,
  input  wire logic [7:0]            wr_addr,
  input  wire logic [15:0]           wr_data,
  input  wire logic                  mute_pin,
  input  wire logic [3:0]            op_mode,
  output tone_regs_pkg::tone_profile_t        tone_profile,
  output logic [2:0]                 treble_level,
  output logic [4:0]                 bass_boost_level,
  output logic                       fast_silence_select,
  output logic                       output_silence,
  output logic                       interpolator_gain_select,
  output logic [2:0]                 deemph_filter_select,
  output logic                       deemph_auto,
  output logic                       output_polarity_invert,
  output logic                       sample_rate_range,
  output logic                       dac_data_from_spdif,
  output logic                       dac_clk_from_xtal,
  output logic                       pll_in_from_ws
);
  import tone_regs_pkg::*;

  // ------------------------------------------------------------------
  // Stored register fields
  // ------------------------------------------------------------------
  tone_profile_t profile_r;
  logic [1:0]    treble_r;
  logic [3:0]    bass_r;
  logic          fast_r;
  logic          silence_r;
  logic          gain_r;
  logic [2:0]    deemph_r;
  logic          pol_r;
  logic          rate_r;
  src_sel_t      src_r;
  logic          deemph_field_on;
  logic          deemph_mode_auto;

  tone_ctrl_if tone_bus ();

  // ------------------------------------------------------------------
  // Register writes; reserved bits and unmapped addresses are dropped
  // ------------------------------------------------------------------

  // Tone register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      profile_r <= PROF_RST;
      treble_r  <= TREBLE_RST;
      bass_r    <= BASS_RST;
    end else if (wr_en && wr_addr == ADDR_TONE) begin
      profile_r <= tone_profile_t'(wr_data[PROF_MSB -: 2]);
      treble_r  <= wr_data[TREBLE_MSB -: 2];
      bass_r    <= wr_data[BASS_MSB -: 4];
    end
  end

  // Mute, gain and de-emphasis register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fast_r    <= FAST_RST;
      silence_r <= SILENCE_RST;
      gain_r    <= GAIN_RST;
      deemph_r  <= DEEMPH_RST;
    end else if (wr_en && wr_addr == ADDR_MUTE) begin
      fast_r    <= wr_data[FAST_BIT];
      silence_r <= wr_data[SILENCE_BIT];
      gain_r    <= wr_data[GAIN_BIT];
      deemph_r  <= wr_data[DEEMPH_MSB -: 3];
    end
  end

  // Polarity, rate range and source register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pol_r  <= POL_RST;
      rate_r <= RATE_RST;
      src_r  <= SRC_RST;
    end else if (wr_en && wr_addr == ADDR_SRC) begin
      pol_r  <= wr_data[POL_BIT];
      rate_r <= wr_data[RATE_BIT];
      src_r  <= src_sel_t'(wr_data[SRC_MSB -: 2]);
    end
  end

  // ------------------------------------------------------------------
  // Tone decoding
  // ------------------------------------------------------------------
  assign tone_bus.profile     = profile_r;
  assign tone_bus.treble_code = treble_r;
  assign tone_bus.bass_code   = bass_r;

  tone_decode u_decode (
    .t (tone_bus.dec)
  );

  // Mode qualification of de-emphasis
  assign deemph_field_on  = (op_mode >= MODE_DE_LO) && (op_mode <= MODE_DE_HI);
  assign deemph_mode_auto = (op_mode == MODE_AUTO_A) || (op_mode == MODE_AUTO_B);

  // ------------------------------------------------------------------
  // Registered outputs to the sound path
  // ------------------------------------------------------------------

  // Tone outputs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tone_profile     <= PROF_RST;
      treble_level     <= 3'h0;
      bass_boost_level <= 5'h0;
    end else begin
      tone_profile     <= profile_r;
      treble_level     <= tone_bus.treble_db;
      bass_boost_level <= tone_bus.bass_db;
    end
  end

  // Mute, gain and de-emphasis outputs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fast_silence_select      <= FAST_RST;
      output_silence           <= SILENCE_RST;
      interpolator_gain_select <= GAIN_RST;
      deemph_filter_select     <= DEEMPH_NONE;
      deemph_auto              <= 1'b0;
    end else begin
      fast_silence_select      <= fast_r;
      output_silence           <= silence_r | mute_pin;
      interpolator_gain_select <= gain_r;
      deemph_filter_select     <= deemph_field_on ? deemph_r : DEEMPH_NONE;
      deemph_auto              <= deemph_mode_auto;
    end
  end

  // Polarity, range and source outputs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      output_polarity_invert <= POL_RST;
      sample_rate_range      <= RATE_RST;
      dac_data_from_spdif    <= (SRC_RST == SRC_SPDIF_PLL);
      dac_clk_from_xtal      <= (SRC_RST == SRC_SER_XTAL);
      pll_in_from_ws         <= (SRC_RST == SRC_SER_PLL_WS);
    end else begin
      output_polarity_invert <= pol_r;
      sample_rate_range      <= rate_r;
      dac_data_from_spdif    <= (src_r == SRC_SPDIF_PLL);
      dac_clk_from_xtal      <= (src_r == SRC_SER_XTAL);
      pll_in_from_ws         <= (src_r == SRC_SER_PLL_WS);
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence tone_write;
    wr_en && wr_addr == ADDR_TONE;
  endsequence

  sequence mute_write;
    wr_en && wr_addr == ADDR_MUTE;
  endsequence

  sequence src_write;
    wr_en && wr_addr == ADDR_SRC;
  endsequence

  chk_profile_update: assert property (
    tone_write |-> ##2 tone_profile == $past(wr_data[PROF_MSB -: 2], 2))
    else $error("tone profile not taken from write");

  chk_treble_level: assert property (
    tone_write ##1 !tone_write |-> ##1 treble_level ==
      ((tone_profile == PROF_MIN || tone_profile == PROF_MAX) ?
       {$past(wr_data[TREBLE_MSB -: 2], 2), 1'b0} : 3'h0))
    else $error("treble level wrong for profile");

  chk_bass_cap: assert property (
    ##1 (bass_boost_level <= ((tone_profile == PROF_MAX) ? BASS_MAX_CAP_DB :
      (tone_profile == PROF_MIN) ? BASS_MIN_CAP_DB : 5'h0)))
    else $error("bass boost above profile limit");

  chk_fast_mute: assert property (
    mute_write |-> ##2 fast_silence_select == $past(wr_data[FAST_BIT], 2))
    else $error("quick mute select not taken");

  chk_mute_or: assert property (
    (mute_pin || silence_r) |=> output_silence)
    else $error("output not muted while mute requested");

  chk_unmute_both: assert property (
    (!mute_pin && !silence_r) |=> !output_silence)
    else $error("output muted with both mute sources low");

  chk_gain_select: assert property (
    mute_write |-> ##2 interpolator_gain_select == $past(wr_data[GAIN_BIT], 2))
    else $error("gain select not taken");

  chk_deemph_mode: assert property (
    !deemph_field_on |=> deemph_filter_select == DEEMPH_NONE)
    else $error("de-emphasis field active outside modes 4 to 8");

  chk_deemph_field: assert property (
    deemph_field_on |=> deemph_filter_select == $past(deemph_r))
    else $error("de-emphasis field not applied");

  chk_polarity_rate: assert property (
    src_write |-> ##2 output_polarity_invert == $past(wr_data[POL_BIT], 2) &&
      sample_rate_range == $past(wr_data[RATE_BIT], 2))
    else $error("polarity or rate range not taken");

  chk_source_map: assert property (
    ##1 !(dac_data_from_spdif && (dac_clk_from_xtal || pll_in_from_ws)) &&
      !(dac_clk_from_xtal && pll_in_from_ws))
    else $error("source selects not mutually exclusive");

  chk_source_write: assert property (
    src_write |-> ##2 dac_data_from_spdif == ($past(wr_data[SRC_MSB -: 2], 2) == SRC_SPDIF_PLL))
    else $error("data source not taken from write");

endmodule

// ### verif/host_model.sv
// Host controller model driving the register write port
`timescale 1ns/1ps
module host_model (
  input  wire logic        ref_clk,
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [15:0]      wr_data
);
  import tone_regs_pkg::*;

  // Idle port at start
  initial begin
    wr_en = 1'b0;
    wr_addr = 8'h00;
    wr_data = 16'h0000;
  end

  // One write: strobe for one cycle, then wait until outputs settle
  task automatic write(input logic [7:0] addr, input logic [15:0] data);
    logic [15:0] d;
    d = data;
    if (addr == ADDR_TONE) begin
      d = d & 16'hFF00;
      if (d[15:14] == 2'h2) d[15:14] = 2'h0;
    end else if (addr == ADDR_MUTE) begin
      d = d & 16'hE700;
    end else if (addr == ADDR_SRC) begin
      d = d & 16'hC300;
    end
    @(negedge ref_clk);
    wr_en = 1'b1;
    wr_addr = addr;
    wr_data = d;
    @(negedge ref_clk);
    wr_en = 1'b0;
    wr_addr = ~addr; // Idle lines carry no stale value
    wr_data = ~d;
    @(negedge ref_clk);
  endtask
endmodule

// ### verif/tb_audio_tone_mute_source_regs.sv
// Self-checking testbench for the tone, mute and source registers
`timescale 1ns/1ps
module tb_audio_tone_mute_source_regs;
  import tone_regs_pkg::*;
  logic          ref_clk;
  logic          reset_n;
  logic          mute_pin;
  logic [3:0]    op_mode;
  logic          wr_en;
  logic [7:0]    wr_addr;
  logic [15:0]   wr_data;
  tone_profile_t tone_profile;
  logic [2:0]    treble_level;
  logic [4:0]    bass_boost_level;
  logic          fast_silence_select;
  logic          output_silence;
  logic          interpolator_gain_select;
  logic [2:0]    deemph_filter_select;
  logic          deemph_auto;
  logic          output_polarity_invert;
  logic          sample_rate_range;
  logic          dac_data_from_spdif;
  logic          dac_clk_from_xtal;
  logic          pll_in_from_ws;
  int            n_fail;
  int            compares;

  host_model host_i (.ref_clk(ref_clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));

  audio_tone_mute_source_regs audio_tone_mute_source_regs_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .mute_pin(mute_pin), .op_mode(op_mode),
    .tone_profile(tone_profile), .treble_level(treble_level),
    .bass_boost_level(bass_boost_level), .fast_silence_select(fast_silence_select),
    .output_silence(output_silence), .interpolator_gain_select(interpolator_gain_select),
    .deemph_filter_select(deemph_filter_select), .deemph_auto(deemph_auto),
    .output_polarity_invert(output_polarity_invert), .sample_rate_range(sample_rate_range),
    .dac_data_from_spdif(dac_data_from_spdif), .dac_clk_from_xtal(dac_clk_from_xtal),
    .pll_in_from_ws(pll_in_from_ws));

  // ----------------------------------------------------------------
  // Clock and helpers
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Compare seen against expected
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic end_sim;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int tr;
    int bb;
    int cap;
    logic [2:0] de;
    n_fail = 0;
    compares = 0;
    reset_n = 1'b0;
    mute_pin = 1'b0;
    op_mode = 4'h4;
    repeat (6) @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    // Reset values of all fields
    check({6'h00, tone_profile, treble_level, bass_boost_level},
          {6'h00, PROF_RST, TREBLE_RST, 1'b0, BASS_RST, 1'b0});
    check({4'h0, fast_silence_select, output_silence, interpolator_gain_select,
           deemph_filter_select, deemph_auto, output_polarity_invert, sample_rate_range,
           dac_data_from_spdif, dac_clk_from_xtal, pll_in_from_ws},
          {4'h0, FAST_RST, SILENCE_RST, GAIN_RST, DEEMPH_RST, 1'b0, POL_RST, RATE_RST,
           3'h4});
    // Flat, min and max profiles with every code; the undefined profile is skipped
    for (int p = 0; p < 4; p++) begin
      if (p == 2) continue;
      for (int c = 0; c < 16; c++) begin
        host_i.write(ADDR_TONE, {p[1:0], c[1:0], c[3:0], 8'h00});
        cap = (p == 1) ? 18 : 24;
        tr = (p == 0) ? 0 : 2 * (c % 4);
        bb = (p == 0) ? 0 : ((2 * c > cap) ? cap : 2 * c);
        check({6'h00, tone_profile, treble_level, bass_boost_level},
              {6'h00, p[1:0], tr[2:0], bb[4:0]});
      end
    end
    // Mute bit, pin, quick mute and gain
    host_i.write(ADDR_MUTE, 16'hA000);
    check({13'h0000, fast_silence_select, output_silence, interpolator_gain_select},
          16'h0005);
    mute_pin = 1'b1;
    @(negedge ref_clk);
    check({15'h0000, output_silence}, 16'h0001);
    mute_pin = 1'b0;
    @(negedge ref_clk);
    check({15'h0000, output_silence}, 16'h0000);
    host_i.write(ADDR_MUTE, 16'h4000);
    check({13'h0000, fast_silence_select, output_silence, interpolator_gain_select},
          16'h0002);
    // De-emphasis codes across operating modes
    for (int c = 0; c < 8; c++) begin
      host_i.write(ADDR_MUTE, {5'h00, c[2:0], 8'h00});
      for (int m = 0; m < 10; m++) begin
        op_mode = m[3:0];
        @(negedge ref_clk);
        de = (m >= 4 && m <= 8) ? c[2:0] : 3'h0;
        check({12'h000, deemph_filter_select, deemph_auto},
              {12'h000, de, (m == 1 || m == 3)});
      end
    end
    // Source codes with polarity and rate
    for (int c = 0; c < 4; c++) begin
      host_i.write(ADDR_SRC, {c[0], c[1], 4'h0, c[1:0], 8'h00});
      check({11'h000, output_polarity_invert, sample_rate_range, dac_data_from_spdif,
             dac_clk_from_xtal, pll_in_from_ws},
      {11'h000, c[0], c[1], (c == 2), (c == 3), (c == 1)});
    end
    // Unmapped addresses leave every register alone
    op_mode = 4'h4;
    host_i.write(8'h10, 16'hFFFF);
    host_i.write(8'h15, 16'hFFFF);
    check({6'h00, tone_profile, treble_level, bass_boost_level},
          {6'h00, 2'h3, 3'h6, 5'h18});
    check({11'h000, output_polarity_invert, sample_rate_range, dac_data_from_spdif,
           dac_clk_from_xtal, pll_in_from_ws}, 16'h001A);
    check({10'h000, fast_silence_select, output_silence, interpolator_gain_select,
           deemph_filter_select}, 16'h0007);
    // Reset in mid-run restores every field except the de-emphasis outputs, which are not checked
    reset_n = 1'b0;
    @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    check({6'h00, tone_profile, treble_level, bass_boost_level},
          {6'h00, PROF_RST, TREBLE_RST, 1'b0, BASS_RST, 1'b0});
    check({11'h000, output_polarity_invert, sample_rate_range, dac_data_from_spdif,
           dac_clk_from_xtal, pll_in_from_ws},
          {11'h000, POL_RST, RATE_RST, 3'h4});
    check({13'h0000, fast_silence_select, output_silence, interpolator_gain_select},
          {13'h0000, FAST_RST, SILENCE_RST, GAIN_RST});
    end_sim();
  end
endmodule
